// *** verilog/perf_event_counter.sv ***
// Performance event sourcing, counter zero and syndrome capture.
// Assumes all event inputs come from pipeline, cache controller and system interface logic on mclk.
`timescale 1ns/1ps
module perf_event_counter
    import perf_event_pkg::*;
#(
    parameter int COUNT_W = 32 // Counter width
)
(
    input wire logic mclk,
    input wire logic rst,
    // Control register zero access
    input wire logic ctl_wr_en,
    input wire logic [31:0] ctl_wr_data,
    output logic [31:0] ctl_rd_data,
    // Counter register zero access
    input wire logic cnt_wr_en,
    input wire logic [COUNT_W-1:0] cnt_wr_data,
    output logic [COUNT_W-1:0] cnt_rd_data,
    // Current privilege mode, one bit per count enable
    input wire logic [3:0] cpu_mode,
    // Decode stage
    input wire logic [2:0] dec_count,
    input wire logic dec_load,
    input wire logic dec_load_excluded,
    input wire logic dec_store,
    input wire logic dec_store_cond,
    // Miss tracking table valid bits
    input wire logic [4:0] miss_tracking_table_valid,
    // Graduation and branch unit
    input wire logic sc_fail,
    input wire logic [2:0] br_resolved,
    // Cache controller and system interface
    input wire logic qw_writeback,
    input wire logic ecc_corrected,
    input wire logic ifetch_miss_enter,
    input wire logic irefill_sent,
    input wire logic iway_retry,
    // Secondary cache read path
    input wire logic [127:0] scache_read_data,
    input wire logic [8:0] scache_check_bits,
    input wire logic scache_rd_valid,
    input wire logic [1:0] scache_rd_src,
    input wire logic scache_err_single,
    input wire logic scache_err_multi,
    // Transaction queue occupancy handshake
    input wire logic sctq_int_push,
    input wire logic sctq_int_pop,
    input wire logic sctq_ext_push,
    input wire logic sctq_ext_pop,
    output logic sctq_int_ready,
    output logic sctq_ext_ready,
    output logic [2:0] sctq_int_count
);
    // Refuse widths below 8 or above 32, at elaboration
    if (COUNT_W < 8 || COUNT_W > 32) begin : g_bad_width
        $error("COUNT_W must lie between 8 and 32");
    end

    // All state of the block
    typedef struct packed {
        logic [SYN_W-1:0] syndrome;  // Last captured syndrome
        logic [CTL_WR_W-1:0] ctl;    // Writable control fields
        logic [COUNT_W-1:0] count;   // Counter zero
        logic [2:0] dec_count_d;     // Decoded count, one cycle late
        logic dec_load_d;            // Counted load, one cycle late
        logic dec_store_d;           // Counted store, one cycle late
        logic ecc_fix_d;             // Correction, one cycle late
        logic ifetch_miss_d;         // Fetch miss entry, one cycle late
        logic irefill_d;             // Refill request, one cycle late
        logic [2:0] q_int;           // Internal queue occupancy
        logic q_ext;                 // External queue slot busy
    } state_t;

    state_t state_reg;  // Registered state
    state_t state_next; // Next state

    // Wires shared with the syndrome generator
    syndrome_if syn_link();

    // Population count of a five-entry valid vector
    function automatic logic [3:0] count_valid(input logic [4:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < MTT_ENTRIES; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    // Current event select
    logic [CTL_EVSEL_W-1:0] ev_sel;
    // Counting allowed in this mode
    logic count_on;
    // Increment chosen for this cycle
    logic [3:0] inc;
    // Syndrome capture strobe
    logic capture;
    // Queue pushes that are actually accepted
    logic int_push_ok;
    logic ext_push_ok;

    // Feed the syndrome generator straight from the read path
    assign syn_link.data = scache_read_data;
    assign syn_link.check = scache_check_bits;

    syndrome_calc u_syndrome (
        .link(syn_link.calc)
    );

    assign ev_sel = state_reg.ctl[CTL_EVSEL_LSB +: CTL_EVSEL_W];
    assign count_on = |(state_reg.ctl[CTL_EN_LSB +: CTL_EN_W] & cpu_mode);

    // Capture on any error from a refill or a writeback only
    always_comb begin
        capture = scache_rd_valid && (scache_err_single || scache_err_multi) &&
                  (scache_rd_src == SRC_REFILL || scache_rd_src == SRC_WRITEBACK);
    end

    // Select the per-cycle increment of the chosen event
    always_comb begin
        inc = 4'h0;
        case (ev_sel)
            // Every processor cycle
            EV_CYCLES: begin
                inc = 4'h1;
            end
            // Instructions decoded last cycle, killed ones included
            EV_DECODED: begin
                inc = {1'b0, state_reg.dec_count_d};
            end
            // Load decoded last cycle
            EV_DEC_LOADS: begin
                inc = {3'h0, state_reg.dec_load_d};
            end
            // Store decoded last cycle
            EV_DEC_STORES: begin
                inc = {3'h0, state_reg.dec_store_d};
            end
            // Valid miss table entries this cycle
            EV_MISS_OCC: begin
                inc = count_valid(miss_tracking_table_valid);
            end
            // Failed store-conditional
            EV_SC_FAIL: begin
                inc = {3'h0, sc_fail};
            end
            // All branches resolved this cycle
            EV_BR_RESOLVED: begin
                inc = {1'b0, br_resolved};
            end
            // Quadword into the outgoing buffer
            EV_QW_WRITEBACK: begin
                inc = {3'h0, qw_writeback};
            end
            // Cycle after a single-bit correction
            EV_ECC_CORR: begin
                inc = {3'h0, state_reg.ecc_fix_d};
            end
            // Cycle after a fetch miss enters the table
            EV_IFETCH_MISS: begin
                inc = {3'h0, state_reg.ifetch_miss_d};
            end
            // Cycle after the refill request reaches the interface
            EV_IREFILL: begin
                inc = {3'h0, state_reg.irefill_d};
            end
            // Retry on an unpredicted way hit by a fetch
            EV_IWAY_RETRY: begin
                inc = {3'h0, iway_retry};
            end
            // Events outside this block count nothing
            default: begin
                inc = 4'h0;
            end
        endcase
    end

    // Queue admission, never more than the fixed slot counts
    always_comb begin
        sctq_int_ready = state_reg.q_int < 3'(SCTQ_INT_SLOTS);
        sctq_ext_ready = !state_reg.q_ext;
        int_push_ok = sctq_int_push && sctq_int_ready;
        ext_push_ok = sctq_ext_push && sctq_ext_ready;
    end

    // Next state
    always_comb begin
        state_next = state_reg;
        // One-cycle delays for the late events
        state_next.dec_count_d = dec_count;
        state_next.dec_load_d = dec_load && !dec_load_excluded;
        state_next.dec_store_d = dec_store || dec_store_cond;
        state_next.ecc_fix_d = ecc_corrected;
        state_next.ifetch_miss_d = ifetch_miss_enter;
        state_next.irefill_d = irefill_sent;
        // Control write touches only the writable fields
        if (ctl_wr_en) begin
            state_next.ctl = ctl_wr_data[CTL_WR_W-1:0];
        end
        // Syndrome is loaded by hardware only
        if (capture) begin
            state_next.syndrome = syn_link.syndrome;
        end
        // Software write wins over counting
        if (cnt_wr_en) begin
            state_next.count = cnt_wr_data;
        end else if (count_on) begin
            state_next.count = state_reg.count + COUNT_W'(inc);
        end
        // Internal queue occupancy
        if (int_push_ok && !sctq_int_pop) begin
            state_next.q_int = state_reg.q_int + 3'h1;
        end else if (!int_push_ok && sctq_int_pop && state_reg.q_int != 3'h0) begin
            state_next.q_int = state_reg.q_int - 3'h1;
        end
        // External slot
        if (ext_push_ok) begin
            state_next.q_ext = 1'b1;
        end else if (sctq_ext_pop) begin
            state_next.q_ext = 1'b0;
        end
    end

    // State register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= '{syndrome: SYN_RESET, ctl: CTL_RESET, count: COUNT_W'(CNT_RESET),
                           dec_count_d: 3'h0, dec_load_d: 1'b0, dec_store_d: 1'b0,
                           ecc_fix_d: 1'b0, ifetch_miss_d: 1'b0, irefill_d: 1'b0,
                           q_int: 3'h0, q_ext: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    // Register read views
    always_comb begin
        ctl_rd_data = 32'h00000000;
        ctl_rd_data[CTL_WR_W-1:0] = state_reg.ctl;
        ctl_rd_data[CTL_SYN_LSB +: SYN_W] = state_reg.syndrome;
    end

    assign cnt_rd_data = state_reg.count;
    assign sctq_int_count = state_reg.q_int;
endmodule

// *** verilog/perf_event_pkg.sv ***
// Constants for the performance event sourcing and syndrome capture block.
// Assumes one processor clock; every event source arrives on that clock.
//
// Function
// - Latch nine syndrome bits on refill or writeback data errors
// - Syndrome reads as control zero bits 31:23
// - Syndrome bits ignore software writes to control
// - Capture on refills and writebacks, never cache-ops
// - Syndrome bit is masked data parity XOR check
// - Event 0 adds one every cycle
// - Event 1 adds previous cycle's decoded instructions
// - Event 2 counts prior-cycle loads, excluding prefetch/sync
// - Event 3 counts prior-cycle stores, including conditionals
// - Event 4 adds valid miss table entries, all five
// - Event 5 counts failed store-conditionals
// - Event 6 adds every resolved branch this cycle
// - Event 7 counts quadwords written back to interface
// - Event 8 counts cycle after corrected single-bit error
// - Event 9 counts cycle after fetch miss entry
// - Event 10 counts cycle after instruction refill request
// - Event 11 counts instruction way-misprediction retries
// - Queue holds four internal, one external transaction
package perf_event_pkg;
    // Control register zero layout
    localparam int CTL_EN_LSB = 0;
    localparam int CTL_EN_W = 4;
    localparam int CTL_EVSEL_LSB = 5;
    localparam int CTL_EVSEL_W = 5;
    localparam int CTL_WR_W = 17;
    localparam int CTL_SYN_LSB = 23;
    localparam int SYN_W = 9;
    localparam logic [16:0] CTL_RESET = 17'h00000;
    localparam logic [8:0] SYN_RESET = 9'h000;
    localparam logic [31:0] CNT_RESET = 32'h00000000;
    // Event select codes
    localparam logic [4:0] EV_CYCLES = 5'h00;
    localparam logic [4:0] EV_DECODED = 5'h01;
    localparam logic [4:0] EV_DEC_LOADS = 5'h02;
    localparam logic [4:0] EV_DEC_STORES = 5'h03;
    localparam logic [4:0] EV_MISS_OCC = 5'h04;
    localparam logic [4:0] EV_SC_FAIL = 5'h05;
    localparam logic [4:0] EV_BR_RESOLVED = 5'h06;
    localparam logic [4:0] EV_QW_WRITEBACK = 5'h07;
    localparam logic [4:0] EV_ECC_CORR = 5'h08;
    localparam logic [4:0] EV_IFETCH_MISS = 5'h09;
    localparam logic [4:0] EV_IREFILL = 5'h0A;
    localparam logic [4:0] EV_IWAY_RETRY = 5'h0B;
    // Secondary cache read source codes
    localparam logic [1:0] SRC_REFILL = 2'h0;
    localparam logic [1:0] SRC_WRITEBACK = 2'h1;
    localparam logic [1:0] SRC_CACHEOP = 2'h2;
    // Transaction queue slots and miss tracking table entries
    localparam int SCTQ_INT_SLOTS = 4;
    localparam int MTT_ENTRIES = 5;
    // Syndrome parity masks over the 128 data bits, one per syndrome bit
    localparam logic [127:0] SYN_MASK [SYN_W] = '{
        128'h01040420_0B0D0B47_04E0FF60_C3FFC0FF,
        128'h04090944_13121008_4DC0E0FF_E0C0FFFF,
        128'h0A121218_23202100_BAFFC0A0_D0FFFFC1,
        128'h10232081_444046BF_FC3FDF3F_4C010142,
        128'h214043FF_808084FF_FF210101_FFC20284,
        128'h42808012_FCFBFC3F_FD620222_8504C408,
        128'h83FFFF03_0503FF5C_808404C4_38484850,
        128'hFFFF030F_FF0703B2_100848C8_02909020,
        128'hFF03FFE3_06FF0721_62D0B0D0_00202080
    };
endpackage

// *** verilog/syndrome_if.sv ***
// Carries one secondary-cache quadword and its syndrome between modules.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface syndrome_if;
    logic [127:0] data;   // Quadword read from the cache
    logic [8:0] check;    // Stored check bits
    logic [8:0] syndrome; // Generated syndrome
    modport source (output data, output check, input syndrome);
    modport calc (input data, input check, output syndrome);
endinterface

// *** verilog/syndrome_calc.sv ***
// Combinational syndrome generator for one 128-bit quadword.
// Assumes the masks in the package; no state of its own.
`timescale 1ns/1ps
module syndrome_calc
    import perf_event_pkg::*;
(
    syndrome_if.calc link
);
    // One parity tree per syndrome bit
    genvar k;
    generate
        for (k = 0; k < SYN_W; k++) begin : g_bit
            // Masked data parity folded with the matching check bit
            assign link.syndrome[k] = (^(link.data & SYN_MASK[k])) ^ link.check[k];
        end
    endgenerate
endmodule

// *** test/event_source_model.sv ***
// Pipeline, cache controller and system interface stand-in.
// Assumes ev changes at the falling edge, one source active at a time.
`timescale 1ns/1ps
module event_source_model (
    input wire logic [3:0] ev,
    input wire logic [2:0] amt,
    output logic [2:0] dec_count,
    output logic dec_load,
    output logic dec_load_excluded,
    output logic dec_store,
    output logic dec_store_cond,
    output logic [4:0] miss_tracking_table_valid,
    output logic sc_fail,
    output logic [2:0] br_resolved,
    output logic qw_writeback,
    output logic ecc_corrected,
    output logic ifetch_miss_enter,
    output logic irefill_sent,
    output logic iway_retry
);
    // Codes 1 to B pulse one source; C is an excluded load, D a conditional store
    always_comb begin
        dec_count = (ev == 4'h1) ? amt : 3'h0;
        dec_load = ev == 4'h2 || ev == 4'hC;
        dec_load_excluded = ev == 4'hC;
        dec_store = ev == 4'h3 || ev == 4'hD;
        dec_store_cond = ev == 4'hD;
        miss_tracking_table_valid = (ev == 4'h4) ? 5'((6'h01 << amt) - 6'h01) : 5'h00;
        sc_fail = ev == 4'h5;
        br_resolved = (ev == 4'h6) ? amt : 3'h0;
        qw_writeback = ev == 4'h7;
        ecc_corrected = ev == 4'h8;
        ifetch_miss_enter = ev == 4'h9;
        irefill_sent = ev == 4'hA;
        iway_retry = ev == 4'hB;
    end
endmodule

// *** test/perf_event_chk.sv ***
// Assertions on the counter block's top ports.
// Assumes the single clock mclk and asynchronous reset rst.
`timescale 1ns/1ps
module perf_event_chk
    import perf_event_pkg::*;
#(
    parameter int COUNT_W = 32
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ctl_wr_en,
    input wire logic [31:0] ctl_wr_data,
    input wire logic [31:0] ctl_rd_data,
    input wire logic cnt_wr_en,
    input wire logic [COUNT_W-1:0] cnt_wr_data,
    input wire logic [COUNT_W-1:0] cnt_rd_data,
    input wire logic [3:0] cpu_mode,
    input wire logic [2:0] dec_count,
    input wire logic [127:0] scache_read_data,
    input wire logic [8:0] scache_check_bits,
    input wire logic scache_rd_valid,
    input wire logic [1:0] scache_rd_src,
    input wire logic scache_err_single,
    input wire logic scache_err_multi,
    input wire logic sctq_int_push,
    input wire logic sctq_int_pop,
    input wire logic [2:0] sctq_int_count
);
    logic [8:0] syn_calc; // Syndrome of the present read data
    logic take; // Capture condition this cycle
    logic on; // Counting, no register write
    // Parity of each masked data subset with its check bit
    always_comb begin
        for (int k = 0; k < SYN_W; k++) begin
            syn_calc[k] = ^(scache_read_data & SYN_MASK[k]) ^ scache_check_bits[k];
        end
    end
    assign take = scache_rd_valid && (scache_err_single || scache_err_multi)
        && (scache_rd_src == SRC_REFILL || scache_rd_src == SRC_WRITEBACK);
    assign on = (ctl_rd_data[3:0] & cpu_mode) != 4'h0 && !cnt_wr_en && !ctl_wr_en;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Counting cycle with a given event selected
    sequence selected(logic [4:0] code);
        on && ctl_rd_data[9:5] == code;
    endsequence
    syn_capture_a:
        assert property (take |=> ctl_rd_data[31:23] == $past(syn_calc)) else $error("syndrome not captured");
    syn_hold_a:
        assert property (!take |=> $stable(ctl_rd_data[31:23])) else $error("syndrome moved");
    ctl_write_a:
        assert property (ctl_wr_en |=> ctl_rd_data[16:0] == $past(ctl_wr_data[16:0])) else $error("control lost");
    cnt_write_a:
        assert property (cnt_wr_en |=> cnt_rd_data == $past(cnt_wr_data)) else $error("count write lost");
    cycle_count_a:
        assert property (selected(EV_CYCLES) |=> cnt_rd_data == COUNT_W'($past(cnt_rd_data) + 1))
        else $error("cycle count wrong");
    decoded_add_a:
        assert property (selected(EV_DECODED) ##1 selected(EV_DECODED)
            |=> cnt_rd_data == COUNT_W'($past(cnt_rd_data) + $past(dec_count, 2))) else $error("decode count wrong");
    queue_push_a:
        assert property (sctq_int_push && !sctq_int_pop && sctq_int_count < 3'h4
            |=> sctq_int_count == $past(sctq_int_count) + 3'h1) else $error("push not taken");
    queue_refuse_a:
        assert property (sctq_int_push && !sctq_int_pop && sctq_int_count == 3'h4 |=> sctq_int_count == 3'h4)
        else $error("queue overfilled");
endmodule

// *** test/tb_top.sv ***
// Self-checking bench for event sourcing and syndrome capture.
// Assumes the source model drives every pipeline-side event input.
`timescale 1ns/1ps
module tb_top;
    import perf_event_pkg::*;
    logic mclk, rst, ctl_wr_en, cnt_wr_en, scache_rd_valid, scache_err_single, scache_err_multi;
    logic sctq_int_push, sctq_int_pop, sctq_ext_push, sctq_ext_pop, sctq_int_ready, sctq_ext_ready;
    logic dec_load, dec_load_excluded, dec_store, dec_store_cond, sc_fail, qw_writeback;
    logic ecc_corrected, ifetch_miss_enter, irefill_sent, iway_retry;
    logic [31:0] ctl_wr_data, ctl_rd_data, cnt_wr_data, cnt_rd_data;
    logic [3:0] cpu_mode, ev;
    logic [2:0] dec_count, br_resolved, amt, sctq_int_count;
    logic [4:0] miss_tracking_table_valid;
    logic [127:0] scache_read_data;
    logic [8:0] scache_check_bits, syn_exp;
    logic [1:0] scache_rd_src;
    int bad_count, comparisons;
    // Select, source code, amount, expected count
    localparam logic [19:0] EV_TBL [16] = '{
        {5'h00, 4'hF, 3'h0, 8'h04}, {5'h01, 4'h1, 3'h7, 8'h07}, {5'h02, 4'h2, 3'h1, 8'h01},
        {5'h02, 4'hC, 3'h1, 8'h00}, {5'h03, 4'h3, 3'h1, 8'h01}, {5'h03, 4'hD, 3'h1, 8'h01},
        {5'h04, 4'h4, 3'h5, 8'h05}, {5'h05, 4'h5, 3'h1, 8'h01}, {5'h06, 4'h6, 3'h3, 8'h03},
        {5'h07, 4'h7, 3'h1, 8'h01}, {5'h08, 4'h8, 3'h1, 8'h01}, {5'h09, 4'h9, 3'h1, 8'h01},
        {5'h0A, 4'hA, 3'h1, 8'h01}, {5'h0B, 4'hB, 3'h1, 8'h01}, {5'h05, 4'h7, 3'h1, 8'h00},
        {5'h0C, 4'hF, 3'h0, 8'h00}
    };
    perf_event_counter i_dut (.*);
    event_source_model i_src (.*);
    // Free-running processor clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // Register write; enables stay up for back-to-back use
    task automatic reg_wr(input logic to_ctl, input logic [31:0] d);
        ctl_wr_en = to_ctl;
        cnt_wr_en = !to_ctl;
        ctl_wr_data = d;
        cnt_wr_data = d;
        tick(1);
    endtask
    // One cache read; valid stays up for back-to-back use
    task automatic syn_try(input logic [1:0] src, input logic s, input logic m, input logic [127:0] d,
        input logic [8:0] c, input logic take);
        {scache_rd_src, scache_err_single, scache_err_multi, scache_rd_valid} = {src, s, m, 1'b1};
        scache_read_data = d;
        scache_check_bits = c;
        for (int k = 0; k < SYN_W; k++) begin
            if (take) syn_exp[k] = ^(d & SYN_MASK[k]) ^ c[k];
        end
        tick(1);
        check({23'h0, ctl_rd_data[31:23]}, {23'h0, syn_exp}, "syndrome");
    endtask
    task automatic wrap_up();
        $display("mismatches %0d, comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Watchdog well past the expected run
    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end
    // Main sequence
    initial begin
        {rst, ctl_wr_en, cnt_wr_en, scache_rd_valid, scache_err_single, scache_err_multi} = 6'h20;
        {sctq_int_push, sctq_int_pop, sctq_ext_push, sctq_ext_pop} = 4'h0;
        {ctl_wr_data, cnt_wr_data, scache_read_data, scache_check_bits, scache_rd_src} = '0;
        {cpu_mode, ev, amt} = {4'h1, 4'hF, 3'h0};
        syn_exp = 9'h000;
        tick(4);
        rst = 1'b0;
        check(ctl_rd_data | cnt_rd_data, 32'h0, "reset registers");
        check({27'h0, sctq_int_ready, sctq_ext_ready, sctq_int_count}, 32'h18, "reset queue");
        {sctq_int_push, sctq_ext_push} = 2'b11;
        tick(5);
        check({27'h0, sctq_int_ready, sctq_ext_ready, sctq_int_count}, 32'h04, "queue full");
        {sctq_int_push, sctq_ext_push, sctq_int_pop, sctq_ext_pop} = 4'h3;
        tick(5);
        check({27'h0, sctq_int_ready, sctq_ext_ready, sctq_int_count}, 32'h18, "queue empty");
        {sctq_int_pop, sctq_ext_pop} = 2'b00;
        $display("queue test done");
        foreach (EV_TBL[i]) begin
            reg_wr(1'b1, {22'h0, EV_TBL[i][19:15], 5'h01});
            reg_wr(1'b0, 32'h0);
            {ctl_wr_en, cnt_wr_en} = 2'b00;
            {ev, amt} = EV_TBL[i][14:8];
            tick(1);
            ev = 4'hF;
            tick(3);
            check(cnt_rd_data, {24'h0, EV_TBL[i][7:0]}, "event count");
        end
        $display("event test done");
        syn_try(SRC_REFILL, 1'b1, 1'b0, {4{32'h12345678}}, 9'h0A5, 1'b1);
        syn_try(SRC_WRITEBACK, 1'b0, 1'b1, {4{32'hDEADBEEF}}, 9'h13C, 1'b1);
        syn_try(SRC_CACHEOP, 1'b1, 1'b1, {4{32'h0F0F1234}}, 9'h1FF, 1'b0);
        syn_try(SRC_REFILL, 1'b0, 1'b0, {4{32'h0000FFFF}}, 9'h055, 1'b0);
        for (int i = 0; i < 128; i += 9) syn_try(SRC_REFILL, 1'b1, 1'b0, 128'h1 << i, 9'h000, 1'b1);
        scache_rd_valid = 1'b0;
        reg_wr(1'b1, 32'hFFFFFFFF);
        ctl_wr_en = 1'b0;
        check(ctl_rd_data, {syn_exp, 6'h00, 17'h1FFFF}, "control readback");
        $display("syndrome test done");
        wrap_up();
    end
endmodule
bind perf_event_counter perf_event_chk #(.COUNT_W(COUNT_W)) i_chk (.*);
